// ===== iox_pkg.sv
`default_nettype none
package iox_pkg;
	// fixed upper four bits of the slave address
	localparam logic [3:0] IOX_ADDR_FIXED = 4'h4;
	// register pointer values carried by the command byte
	localparam logic [1:0] IOX_PTR_PIN_LEVEL_SAMPLE  = 2'h0;
	localparam logic [1:0] IOX_PTR_PIN_DRIVE_LEVEL   = 2'h1;
	localparam logic [1:0] IOX_PTR_INPUT_INVERT_MASK = 2'h2;
	localparam logic [1:0] IOX_PTR_PIN_DIRECTION     = 2'h3;
	// values after reset
	localparam logic [1:0] IOX_PTR_RST       = 2'h0;
	localparam logic [7:0] IOX_DRIVE_RST     = 8'hFF;
	localparam logic [7:0] IOX_INVERT_RST    = 8'h00;
	localparam logic [7:0] IOX_DIRECTION_RST = 8'hFF;
	localparam logic [7:0] IOX_SNAPSHOT_RST  = 8'hFF;
	// controller registers on the apb side, byte addresses
	localparam logic [7:0] IOX_APB_CTRL = 8'h00;
	localparam logic [7:0] IOX_APB_DATA = 8'h04;
	localparam logic [7:0] IOX_APB_STAT = 8'h08;
	// controller field positions
	localparam int IOX_CTRL_GO        = 0;
	localparam int IOX_CTRL_READ      = 1;
	localparam int IOX_CTRL_WITH_CMD  = 2;
	localparam int IOX_CTRL_WITH_DATA = 3;
	localparam int IOX_CTRL_STRAP_LSB = 4;
	localparam int IOX_DATA_CMD_LSB   = 0;
	localparam int IOX_DATA_WR_LSB    = 8;
	localparam int IOX_STAT_BUSY      = 0;
	localparam int IOX_STAT_NACK      = 1;
	localparam int IOX_STAT_RDATA_LSB = 8;
	// serial clock timing: fastest clock rate, quarter period in cycles rounded up
	localparam longint IOX_CLK_HZ     = 200_000_000;
	localparam longint IOX_SCL_MAX_HZ = 400_000;
	localparam int     IOX_QTR_CYC    = int'((IOX_CLK_HZ + 4 * IOX_SCL_MAX_HZ - 1)
		/ (4 * IOX_SCL_MAX_HZ));
endpackage
`default_nettype wire

// ===== iox_if.sv
`timescale 1ns/1ps
`default_nettype none
interface iox_if;
	logic scl;          // serial clock, driven by the controller
	logic host_sda_o;   // controller data level
	logic host_sda_oe_n; // controller drives when low
	logic dev_sda_o;    // expander data level
	logic dev_sda_oe_n; // expander drives when low
	logic sda;          // resolved data line, pulled up when nobody pulls low
	// open-drain wire: any enabled low driver wins
	assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
	modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
endinterface
`default_nettype wire

// ===== iox_expander.sv
// Local design decision: register access over the serial bus; APB is on the controller only.
`timescale 1ns/1ps
`default_nettype none
module iox_expander
	import iox_pkg::*;
(
	input  wire logic       CLK_I,        // system clock
	input  wire logic       RST_I,        // async reset, active high
	iox_if.dev              bus,          // serial bus lines
	input  wire logic [2:0] ADDR_STRAP_I, // addr_strap_bit2..0
	input  wire logic [7:0] GPIO_I,       // pin levels
	output logic      [7:0] GPIO_O,       // pin drive levels
	output logic      [7:0] GPIO_OE_N_O,  // pin driven when low
	output logic            ALERT_O,      // alert pin level
	output logic            ALERT_OE_N_O  // alert pulls low when low
);
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT} iox_state_e;

	// synchronisers: first stage only feeds the second
	logic [7:0] gpio_s1_r;   // pins, stage one
	logic [7:0] gpio_s2_r;   // pins, stage two
	logic [2:0] strap_s1_r;  // strap, stage one
	logic [2:0] strap_s2_r;  // strap, stage two
	logic       scl_s1_r;    // clock, stage one
	logic       scl_s2_r;    // clock, stage two
	logic       scl_d_r;     // clock, previous sample for edges
	logic       sda_s1_r;    // data, stage one
	logic       sda_s2_r;    // data, stage two
	logic       sda_d_r;     // data, previous sample for edges

	// protocol state
	iox_state_e state_r;     // byte engine state
	logic [3:0] bit_cnt_r;   // bits of the current byte
	logic [1:0] byte_no_r;   // 0 address, 1 command, 2 data
	logic [7:0] shift_r;     // receive or transmit shifter
	logic       rw_r;        // direction bit of this transaction
	logic       mack_r;      // master acknowledged last read byte
	logic       sda_low_r;   // we pull the data line low

	// device registers
	logic [1:0] ptr_r;                 // register pointer
	logic [7:0] pin_drive_level_r;     // output flip-flops
	logic [7:0] input_invert_mask_r;   // polarity mask
	logic [7:0] pin_direction_r;       // one means input
	logic [7:0] snapshot_r;            // pin levels at last input read
	logic       alert_r;               // alert asserted

	// edge and condition decode
	wire        scl_rise  = scl_s2_r & ~scl_d_r;
	wire        scl_fall  = ~scl_s2_r & scl_d_r;
	wire        start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	wire        stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
	wire        addr_hit  = (shift_r[7:1] == {IOX_ADDR_FIXED, strap_s2_r});
	wire [7:0]  pin_level_sample = gpio_s2_r ^ input_invert_mask_r;
	// every source is an argument, so the wire follows live pin changes too
	wire [7:0]  rd_data   = rd_sel(ptr_r, pin_level_sample, pin_drive_level_r,
		input_invert_mask_r, pin_direction_r);
	// a new read byte is loaded after the address ack or a master ack
	wire        tx_load   = ~start_det & ~stop_det & scl_fall &
		(((state_r == ST_RX_ACK) & (byte_no_r == 2'h0) & rw_r) |
		 ((state_r == ST_TX_ACK) & mack_r));

	// register read selection, used at every byte load
	function automatic logic [7:0] rd_sel(input logic [1:0] p, input logic [7:0] lvl,
		input logic [7:0] drv, input logic [7:0] inv, input logic [7:0] dir);
		unique case (p)
			IOX_PTR_PIN_LEVEL_SAMPLE:  rd_sel = lvl;
			IOX_PTR_PIN_DRIVE_LEVEL:   rd_sel = drv;
			IOX_PTR_INPUT_INVERT_MASK: rd_sel = inv;
			IOX_PTR_PIN_DIRECTION:     rd_sel = dir;
		endcase
	endfunction

	// two-flop synchronisers plus one edge-history stage
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			gpio_s1_r  <= 8'hFF;
			gpio_s2_r  <= 8'hFF;
			strap_s1_r <= 3'h0;
			strap_s2_r <= 3'h0;
			{scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
			{sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
		end else begin
			gpio_s1_r  <= GPIO_I;
			gpio_s2_r  <= gpio_s1_r;
			strap_s1_r <= ADDR_STRAP_I;
			strap_s2_r <= strap_s1_r;
			{scl_s1_r, scl_s2_r, scl_d_r} <= {bus.scl, scl_s1_r, scl_s2_r};
			{sda_s1_r, sda_s2_r, sda_d_r} <= {bus.sda, sda_s1_r, sda_s2_r};
		end
	end

	// byte engine; start and stop override any state, so a repeated start restarts
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r             <= ST_IDLE;
			bit_cnt_r           <= 4'h0;
			byte_no_r           <= 2'h0;
			shift_r             <= 8'h00;
			rw_r                <= 1'b0;
			mack_r              <= 1'b0;
			sda_low_r           <= 1'b0;
			ptr_r               <= IOX_PTR_RST;
			pin_drive_level_r   <= IOX_DRIVE_RST;
			input_invert_mask_r <= IOX_INVERT_RST;
			pin_direction_r     <= IOX_DIRECTION_RST;
		end else if (start_det) begin
			// a start may come at any time, even inside a byte
			state_r   <= ST_RX;
			bit_cnt_r <= 4'h0;
			byte_no_r <= 2'h0;
			sda_low_r <= 1'b0;
		end else if (stop_det) begin
			state_r   <= ST_IDLE;
			sda_low_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE, ST_WAIT: begin
					// ignore everything but start and stop
					sda_low_r <= 1'b0;
				end
				ST_RX: begin
					if (scl_rise && bit_cnt_r != 4'h8) begin
						// sample while clock high, line is stable then
						shift_r   <= {shift_r[6:0], sda_s2_r};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						if (byte_no_r == 2'h0 && !addr_hit) begin
							state_r <= ST_WAIT;
						end else begin
							// pull low for the whole ninth clock
							sda_low_r <= 1'b1;
							state_r   <= ST_RX_ACK;
							if (byte_no_r == 2'h0) begin
								rw_r <= shift_r[0];
							end
							if (byte_no_r == 2'h1) begin
								ptr_r <= shift_r[1:0];
							end
						end
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (byte_no_r == 2'h0 && rw_r) begin
							// first read bit goes out right after the ack
							state_r   <= ST_TX;
							shift_r   <= rd_data;
							sda_low_r <= ~rd_data[7];
						end else begin
							state_r   <= ST_RX;
							sda_low_r <= 1'b0;
							byte_no_r <= (byte_no_r == 2'h0) ? 2'h1 : 2'h2;
							if (byte_no_r == 2'h2) begin
								// store after the ack; input register ignores writes
								unique case (ptr_r)
									IOX_PTR_PIN_LEVEL_SAMPLE: ;
									IOX_PTR_PIN_DRIVE_LEVEL:   pin_drive_level_r <= shift_r;
									IOX_PTR_INPUT_INVERT_MASK: input_invert_mask_r <= shift_r;
									IOX_PTR_PIN_DIRECTION:     pin_direction_r <= shift_r;
								endcase
							end
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_r == 4'h7) begin
							// release for the master's ack
							state_r   <= ST_TX_ACK;
							sda_low_r <= 1'b0;
						end else begin
							shift_r   <= {shift_r[6:0], 1'b0};
							sda_low_r <= ~shift_r[6];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						mack_r <= ~sda_s2_r;
					end else if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (mack_r) begin
							state_r   <= ST_TX;
							shift_r   <= rd_data;
							sda_low_r <= ~rd_data[7];
						end else begin
							// no ack: stay off the line until stop
							state_r <= ST_WAIT;
						end
					end
				end
			endcase
		end
	end

	// snapshot taken when the input register is loaded for reading
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			snapshot_r <= IOX_SNAPSHOT_RST;
		end else if (tx_load && ptr_r == IOX_PTR_PIN_LEVEL_SAMPLE) begin
			snapshot_r <= gpio_s2_r;
		end
	end

	// alert follows input pins that differ from the last read value;
	// compares raw levels, so a pin turned to input can raise it at once
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			alert_r <= 1'b0;
		end else begin
			alert_r <= |(pin_direction_r & (gpio_s2_r ^ snapshot_r));
		end
	end

	// pin drivers: direction one turns the driver off
	assign GPIO_O       = pin_drive_level_r;
	assign GPIO_OE_N_O  = pin_direction_r;
	assign ALERT_O      = 1'b0;
	assign ALERT_OE_N_O = ~alert_r;
	// open-drain data: we only ever pull low
	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe_n = ~sda_low_r;
endmodule // iox_expander
`default_nettype wire

// ===== iox_controller.sv
`timescale 1ns/1ps
`default_nettype none
module iox_controller
	import iox_pkg::*;
#(
	parameter int QTR_CYC = IOX_QTR_CYC // cycles per quarter of a serial bit
)(
	input  wire logic        CLK_I,     // system clock
	input  wire logic        RST_I,     // async reset, active high
	input  wire logic        PSEL_I,    // apb select
	input  wire logic        PENABLE_I, // apb access phase
	input  wire logic        PWRITE_I,  // apb write
	input  wire logic [7:0]  PADDR_I,   // apb byte address
	input  wire logic [31:0] PWDATA_I,  // apb write data
	output logic      [31:0] PRDATA_O,  // apb read data
	output logic             PREADY_O,  // apb ready
	output logic             PSLVERR_O, // apb error on unmapped address
	iox_if.host              bus        // serial bus lines
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} iox_hstate_e;

	// quarter counter needs room; too small a quarter outruns the far sampler
	if (QTR_CYC < 8 || QTR_CYC > 65535) begin : g_bad_qtr
		$error("QTR_CYC out of range");
	end

	logic [15:0] qcnt_r;      // quarter-period divider
	logic        sda_s1_r;    // data line, stage one
	logic        sda_s2_r;    // data line, stage two
	iox_hstate_e state_r;     // transaction state
	logic [1:0]  phase_r;     // quarter within a bit
	logic [3:0]  bit_cnt_r;   // bit within a nine-bit slot
	logic [1:0]  byte_no_r;   // byte within the transaction
	logic [8:0]  tx_r;        // byte plus released ack slot
	logic [8:0]  rx_r;        // sampled line levels
	logic        scl_r;       // serial clock level
	logic        sda_low_r;   // we pull data low
	logic        busy_r;      // transaction pending or running
	logic        nack_r;      // last transaction saw no ack
	logic        rd_r;        // read transaction
	logic        with_cmd_r;  // send command byte
	logic        with_dat_r;  // send data byte
	logic [2:0]  strap_r;     // target strap address
	logic [7:0]  cmd_byte_r;  // command byte
	logic [7:0]  wr_byte_r;   // data byte
	logic [7:0]  rdata_r;     // byte read back
	logic [31:0] prdata_r;    // registered read data

	wire        tick      = (qcnt_r == 16'(QTR_CYC - 1));
	wire        apb_acc   = PSEL_I & PENABLE_I;
	wire        apb_setup = PSEL_I & ~PENABLE_I;
	wire        mapped    = (PADDR_I == IOX_APB_CTRL) | (PADDR_I == IOX_APB_DATA) |
		(PADDR_I == IOX_APB_STAT);
	wire        go_wr     = apb_acc & PWRITE_I & (PADDR_I == IOX_APB_CTRL) & ~busy_r &
		PWDATA_I[IOX_CTRL_GO];
	wire        data_wr   = apb_acc & PWRITE_I & (PADDR_I == IOX_APB_DATA) & ~busy_r;
	wire [1:0]  last_byte = rd_r ? 2'h1 : (with_dat_r ? 2'h2 : {1'b0, with_cmd_r});
	wire        slave_acks = ~(rd_r & (byte_no_r != 2'h0));
	wire [31:0] rd_mux    =
		(PADDR_I == IOX_APB_CTRL) ? {25'h0, strap_r, with_dat_r, with_cmd_r, rd_r, 1'b0} :
		(PADDR_I == IOX_APB_DATA) ? {16'h0, wr_byte_r, cmd_byte_r} :
		(PADDR_I == IOX_APB_STAT) ? {16'h0, rdata_r, 6'h0, nack_r, busy_r} : 32'h0;

	// byte sent in slot n; a read byte is all ones so the line stays released
	function automatic logic [7:0] byte_for(input logic [1:0] n);
		if (n == 2'h0) begin
			byte_for = {IOX_ADDR_FIXED, strap_r, rd_r};
		end else if (rd_r) begin
			byte_for = 8'hFF;
		end else begin
			byte_for = (n == 2'h1) ? cmd_byte_r : wr_byte_r;
		end
	endfunction

	// divider and data synchroniser
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			qcnt_r   <= 16'h0;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
		end else begin
			qcnt_r   <= tick ? 16'h0 : qcnt_r + 16'h1;
			sda_s1_r <= bus.sda;
			sda_s2_r <= sda_s1_r;
		end
	end

	// apb read data captured in the setup cycle
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			prdata_r <= 32'h0;
		end else if (apb_setup) begin
			prdata_r <= rd_mux;
		end
	end

	// order intake and serial sequencer
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= H_IDLE;
			{phase_r, bit_cnt_r, byte_no_r} <= 8'h0;
			tx_r <= 9'h1FF;
			rx_r <= 9'h0;
			{scl_r, sda_low_r, busy_r, nack_r} <= 4'h8;
			{rd_r, with_cmd_r, with_dat_r, strap_r} <= 6'h0;
			{cmd_byte_r, wr_byte_r, rdata_r} <= 24'h0;
		end else begin
			if (data_wr) begin
				cmd_byte_r <= PWDATA_I[IOX_DATA_CMD_LSB +: 8];
				wr_byte_r  <= PWDATA_I[IOX_DATA_WR_LSB +: 8];
			end
			if (go_wr) begin
				busy_r     <= 1'b1;
				nack_r     <= 1'b0;
				rd_r       <= PWDATA_I[IOX_CTRL_READ];
				with_cmd_r <= PWDATA_I[IOX_CTRL_WITH_CMD] | PWDATA_I[IOX_CTRL_WITH_DATA];
				with_dat_r <= PWDATA_I[IOX_CTRL_WITH_DATA];
				strap_r    <= PWDATA_I[IOX_CTRL_STRAP_LSB +: 3];
			end
			if (tick) begin
				unique case (state_r)
					H_IDLE: begin
						// begin only on an idle bus: data high with clock high
						if (busy_r && sda_s2_r) begin
							state_r <= H_START;
							phase_r <= 2'h0;
						end
					end
					H_START: begin
						phase_r <= phase_r + 2'h1;
						if (phase_r == 2'h0) begin
							sda_low_r <= 1'b1;
						end else if (phase_r == 2'h1) begin
							scl_r     <= 1'b0;
							tx_r      <= {byte_for(2'h0), 1'b1};
							byte_no_r <= 2'h0;
							bit_cnt_r <= 4'h0;
							state_r   <= H_BIT;
							phase_r   <= 2'h0;
						end
					end
					H_BIT: begin
						phase_r <= phase_r + 2'h1;
						unique case (phase_r)
							2'h0: sda_low_r <= ~tx_r[8];
							2'h1: scl_r <= 1'b1;
							2'h2: rx_r <= {rx_r[7:0], sda_s2_r};
							2'h3: begin
								scl_r     <= 1'b0;
								tx_r      <= {tx_r[7:0], 1'b0};
								bit_cnt_r <= bit_cnt_r + 4'h1;
								if (bit_cnt_r == 4'h8) begin
									bit_cnt_r <= 4'h0;
									if (slave_acks && rx_r[0]) begin
										nack_r  <= 1'b1;
										state_r <= H_STOP;
									end else if (byte_no_r == last_byte) begin
										if (!slave_acks) begin
											rdata_r <= rx_r[8:1];
										end
										state_r <= H_STOP;
									end else begin
										byte_no_r <= byte_no_r + 2'h1;
										tx_r      <= {byte_for(byte_no_r + 2'h1), 1'b1};
									end
								end
							end
						endcase
					end
					H_STOP: begin
						phase_r <= phase_r + 2'h1;
						unique case (phase_r)
							2'h0: sda_low_r <= 1'b1;
							2'h1: scl_r <= 1'b1;
							2'h2: sda_low_r <= 1'b0;
							2'h3: begin
								busy_r  <= 1'b0;
								state_r <= H_IDLE;
							end
						endcase
					end
				endcase
			end
		end
	end

	assign PRDATA_O          = prdata_r;
	assign PREADY_O          = 1'b1;
	assign PSLVERR_O         = apb_acc & ~mapped;
	assign bus.scl           = scl_r;
	assign bus.host_sda_o    = 1'b0;
	assign bus.host_sda_oe_n = ~sda_low_r;
endmodule // iox_controller
`default_nettype wire

// ===== iox_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module iox_monitor
	import iox_pkg::*;
#(
	parameter logic [2:0] STRAP = 3'h0 // strap level of the watched expander
)(
	input wire logic CLK_I,         // system clock
	input wire logic RST_I,         // async reset, active high
	input wire logic scl,           // serial clock
	input wire logic host_sda_o,    // controller data level
	input wire logic host_sda_oe_n, // controller drives when low
	input wire logic dev_sda_o,     // expander data level
	input wire logic dev_sda_oe_n,  // expander drives when low
	input wire logic sda            // resolved data line
);
	default clocking dc @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	logic       scl_r;   // clock one cycle ago
	logic       sda_r;   // data one cycle ago
	logic       frame_r; // between start and stop
	logic       match_r; // address byte was ours
	logic       rd_r;    // frame is a read
	logic       nack_r;  // master refused a read byte
	logic [3:0] bit_r;   // clock rises within the byte
	logic [3:0] byte_r;  // bytes finished in the frame
	logic [7:0] shift_r; // bits seen in the byte
	wire start_w = scl & scl_r & sda_r & ~sda;
	wire stop_w  = scl & scl_r & ~sda_r & sda;
	wire rise_w  = scl & ~scl_r;
	wire ninth_w = rise_w & frame_r & (bit_r == 4'h8);
	wire own_w   = (shift_r[7:1] == {IOX_ADDR_FIXED, STRAP});
	// follow the frame: bits, bytes, address and direction
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			scl_r   <= 1'h1;
			sda_r   <= 1'h1;
			frame_r <= 1'h0;
			match_r <= 1'h0;
			rd_r    <= 1'h0;
			nack_r  <= 1'h0;
			bit_r   <= 4'h0;
			byte_r  <= 4'h0;
			shift_r <= 8'h00;
		end else begin
			scl_r <= scl;
			sda_r <= sda;
			// repeated start restarts the count too
			if (start_w) begin
				frame_r <= 1'h1;
				bit_r   <= 4'h0;
				byte_r  <= 4'h0;
				nack_r  <= 1'h0;
			end else if (stop_w) begin
				frame_r <= 1'h0;
			end else if (ninth_w) begin
				bit_r  <= 4'h0;
				byte_r <= byte_r + 4'h1;
				match_r <= (byte_r == 4'h0) ? own_w : match_r;
				rd_r    <= (byte_r == 4'h0) ? shift_r[0] : rd_r;
				nack_r  <= nack_r | ((byte_r != 4'h0) & rd_r & sda);
			end else if (rise_w) begin
				bit_r   <= bit_r + 4'h1;
				shift_r <= {shift_r[6:0], sda};
			end
		end
	end
	property p_idle_quiet;
		!frame_r |-> dev_sda_oe_n;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("expander drove data outside a frame");
	property p_bus_idle;
		!frame_r |-> scl;
	endproperty
	a_bus_idle: assert property (p_bus_idle) else $error("clock low while bus idle");
	property p_dev_stable;
		scl && scl_r |-> $stable(dev_sda_oe_n);
	endproperty
	a_dev_stable: assert property (p_dev_stable) else $error("expander data moved with clock high");
	property p_addr_ack;
		ninth_w && byte_r == 4'h0 |-> dev_sda_oe_n == !own_w;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");
	property p_miss_quiet;
		frame_r && byte_r != 4'h0 && !match_r |-> dev_sda_oe_n;
	endproperty
	a_miss_quiet: assert property (p_miss_quiet) else $error("unselected expander drove data");
	property p_write_ack;
		ninth_w && byte_r != 4'h0 && match_r && !rd_r |-> !dev_sda_oe_n;
	endproperty
	a_write_ack: assert property (p_write_ack) else $error("written byte not acknowledged");
	property p_ack_hold;
		ninth_w && !dev_sda_oe_n |-> !dev_sda_oe_n [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped in clock high");
	property p_read_release;
		ninth_w && byte_r != 4'h0 && rd_r |-> dev_sda_oe_n;
	endproperty
	a_read_release: assert property (p_read_release) else $error("data held in read ack slot");
	property p_nack_quiet;
		nack_r |-> dev_sda_oe_n;
	endproperty
	a_nack_quiet: assert property (p_nack_quiet) else $error("expander sent after refusal");
	property p_host_stable;
		frame_r && scl && scl_r && !stop_w |-> $stable(host_sda_oe_n);
	endproperty
	a_host_stable: assert property (p_host_stable) else $error("controller data moved with clock high");
endmodule // iox_monitor
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb;
	import iox_pkg::*;
	localparam logic [2:0] STRAP = 3'h5; // strap level of the expander
	localparam logic [3:0] GO_W  = 4'hD; // go, with command, with data
	localparam logic [3:0] GO_C  = 4'h5; // go, with command only
	localparam logic [3:0] GO_R  = 4'h3; // go, read one byte
	logic        clk     = 1'h0;
	logic        rst     = 1'h1;
	logic        psel    = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite  = 1'h0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;                // apb read data
	logic        pready;                // apb ready
	logic        pslverr;               // apb error
	logic [7:0]  ext_r   = 8'hFF;       // far-end levels, weak pull-up when idle
	logic [7:0]  gpio_o;                // expander drive levels
	logic [7:0]  gpio_oe_n;             // expander drive enables
	logic        alert_oe_n;            // alert pull, low when asserted
	logic        alert_lvl;             // alert level while pulling
	logic        err_seen;              // slave error of last access
	logic [31:0] st;                    // last status word
	logic [7:0]  rb;                    // last byte read back
	int          miscompares     = 0;
	int          samples_checked = 0;
	// pin wire: driven pins follow the expander, others the far end
	wire logic [7:0] pins = (~gpio_oe_n & gpio_o) | (gpio_oe_n & ext_r);
	iox_if ifc ();
	iox_controller #(.QTR_CYC(8)) iox_controller_inst (.CLK_I(clk), .RST_I(rst),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.bus(ifc.host));
	iox_expander iox_expander_inst (.CLK_I(clk), .RST_I(rst), .bus(ifc.dev),
		.ADDR_STRAP_I(STRAP), .GPIO_I(pins), .GPIO_O(gpio_o), .GPIO_OE_N_O(gpio_oe_n),
		.ALERT_O(alert_lvl), .ALERT_OE_N_O(alert_oe_n));
	iox_monitor #(.STRAP(STRAP)) iox_monitor_inst (.CLK_I(clk), .RST_I(rst), .scl(ifc.scl),
		.host_sda_o(ifc.host_sda_o), .host_sda_oe_n(ifc.host_sda_oe_n),
		.dev_sda_o(ifc.dev_sda_o), .dev_sda_oe_n(ifc.dev_sda_oe_n), .sda(ifc.sda));
	// 200 MHz system clock
	always #2.5 clk = ~clk;
	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one apb transfer; an edge always passes first so psel never toggles twice at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1) begin
			miscompares++;
			results();
		end
		rd = prdata;
		err_seen = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	// one serial operation, polled to completion
	task automatic op(input logic [3:0] ctl, input logic [2:0] tgt, input logic [7:0] cmd,
		input logic [7:0] wd, input logic nk);
		int n;
		logic [31:0] d;
		apb(1'h1, IOX_APB_DATA, {16'h0, wd, cmd}, d);
		apb(1'h1, IOX_APB_CTRL, {25'h0, tgt, ctl}, d);
		n = 0;
		do begin
			apb(1'h0, IOX_APB_STAT, 32'h0, st);
			n++;
		end while (st[IOX_STAT_BUSY] !== 1'h0 && n < 3000);
		if (st[IOX_STAT_BUSY] !== 1'h0) begin
			miscompares++;
			results();
		end
		`CHK("nack", nk, st[IOX_STAT_NACK])
	endtask
	task automatic wreg(input logic [7:0] p, input logic [7:0] v);
		op(GO_W, STRAP, p, v, 1'h0);
	endtask
	// pointer first, then a separate read frame
	task automatic rreg(input logic [7:0] p);
		op(GO_C, STRAP, p, 8'h00, 1'h0);
		op(GO_R, STRAP, 8'h00, 8'h00, 1'h0);
		rb = st[15:8];
	endtask
	// main sequence
	initial begin
		logic [7:0] rst_tab [4];
		rst_tab = '{8'hFF, 8'hFF, 8'h00, 8'hFF};
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		`CHK("oe after reset", 8'hFF, gpio_oe_n)
		`CHK("alert after reset", 1'h1, alert_oe_n)
		for (int i = 0; i < 4; i++) begin
			rreg(8'(i));
			`CHK("reset value", rst_tab[i], rb)
		end
		$display("test reset done");
		ext_r <= 8'h5A;
		wreg(8'h03, 8'hF0);
		wreg(8'h01, 8'h3C);
		`CHK("oe", 8'hF0, gpio_oe_n)
		`CHK("pins", 8'h5C, pins)
		rreg(8'h01);
		`CHK("drive read", 8'h3C, rb)
		rreg(8'h00);
		`CHK("input read", 8'h5C, rb)
		$display("test direction done");
		wreg(8'h02, 8'h81);
		op(GO_R, STRAP, 8'h00, 8'h00, 1'h0);
		`CHK("pointer kept", 8'h81, st[15:8])
		rreg(8'h00);
		`CHK("inverted", 8'hDD, rb)
		wreg(8'h02, 8'h00);
		wreg(8'h00, 8'h00);
		rreg(8'h00);
		`CHK("input ignores write", 8'h5C, rb)
		$display("test invert done");
		`CHK("alert idle", 1'h1, alert_oe_n)
		// bit 5 is an input pin; sync plus register stage fit well inside ten cycles
		ext_r <= 8'h7A;
		repeat (10) @(posedge clk);
		`CHK("alert set", 1'h0, alert_oe_n)
		`CHK("alert level", 1'h0, alert_lvl)
		ext_r <= 8'h5A;
		repeat (10) @(posedge clk);
		`CHK("alert back", 1'h1, alert_oe_n)
		ext_r <= 8'h4A;
		repeat (10) @(posedge clk);
		`CHK("alert again", 1'h0, alert_oe_n)
		rreg(8'h00);
		`CHK("alert read", 1'h1, alert_oe_n)
		// lower pins turn to inputs and show A against stored C
		wreg(8'h03, 8'hFF);
		repeat (10) @(posedge clk);
		`CHK("oe inputs", 8'hFF, gpio_oe_n)
		`CHK("false alert", 1'h0, alert_oe_n)
		$display("test alert done");
		op(GO_W, 3'h2, 8'h01, 8'h00, 1'h1);
		rreg(8'h01);
		`CHK("miss keeps drive", 8'h3C, rb)
		apb(1'h0, 8'h0C, 32'h0, st);
		`CHK("unmapped err", 1'h1, err_seen)
		`CHK("unmapped data", 32'h0, st)
		$display("test address done");
		results();
	end
endmodule // tb
`default_nettype wire
